// [fsr_consts.vh]
// Purpose: Shared constants for the card reader buffer and status slice.
// Assumes: Registers are byte wide and addressed by a 6-bit index.
// Notes:   Offsets are register indices on the host register port.
`ifndef FSR_CONSTS_VH
`define FSR_CONSTS_VH

// ****************************************************************
// Register indices
// ****************************************************************
`define FSR_ADDR_W            6
`define FSR_OFF_STATUS1       6'h07
`define FSR_OFF_STATUS2       6'h08
`define FSR_OFF_DATA          6'h09
`define FSR_OFF_LEVEL         6'h0a
`define FSR_OFF_WARN          6'h0b

// ****************************************************************
// Field positions
// ****************************************************************
`define FSR_S1_CRC_ZERO       6
`define FSR_S1_CRC_DONE       5
`define FSR_S1_IRQ            4
`define FSR_S1_TIMER          3
`define FSR_S1_HI             1
`define FSR_S1_LO             0
`define FSR_S2_OVH_CLR        7
`define FSR_S2_FAST           6
`define FSR_S2_CIPHER         3
`define FSR_S2_PHASE_HI       2
`define FSR_LVL_FLUSH         7
`define FSR_WARN_HI           5

// ****************************************************************
// Reset values
// ****************************************************************
`define FSR_RST_STATUS1       8'h21
`define FSR_RST_STATUS2       8'h00
`define FSR_RST_WARN          6'h08

// ****************************************************************
// Buffer sizes and the timer gate-off code
// ****************************************************************
`define FSR_DEPTH             64
`define FSR_STAGE_DEPTH       8
`define FSR_GATE_OFF          2'h0

`endif

// [fsr_regs.v]
// Purpose: Host buffer and status register slice of a card reader frontend.
// Assumes: All side-band inputs except the temperature alarm share core_clk_i.
// Notes:   Host reads return data one cycle after the read strobe.
`timescale 1ns/1ps
`include "fsr_consts.vh"

// ****************************************************************
// Synchronous FIFO with valid/ready on both sides
// ****************************************************************
module fsr_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             core_clk_i,
   input  wire             rst_n_i,
   input  wire             flush_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   output wire [AW:0]      count_o
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr;
   reg  [AW-1:0]    rd_ptr;
   reg  [AW:0]      count;
   wire             push;
   wire             pop;

   assign in_ready_o  = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr];
   assign count_o     = count;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge core_clk_i) begin
      if (push && !flush_i) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Flush wins over any push or pop in the same cycle.
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else if (flush_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                      : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                      : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // fsr_fifo

// ****************************************************************
// Register slice
// ****************************************************************
module fsr_regs #(
   parameter DEPTH     = `FSR_DEPTH,
   parameter AW        = 6,
   parameter STG_DEPTH = `FSR_STAGE_DEPTH,
   parameter STG_AW    = 3,
   parameter IRQ_N     = 16
) (
   input  wire             core_clk_i,
   input  wire             rst_n_i,
   input  wire [5:0]       reg_addr_i,
   input  wire             reg_wr_i,
   input  wire             reg_rd_i,
   input  wire [7:0]       reg_wdata_i,
   output reg  [7:0]       reg_rdata_o,
   output reg              reg_rvalid_o,
   input  wire             rx_valid_i,
   output wire             rx_ready_o,
   input  wire [7:0]       rx_data_i,
   output wire             tx_valid_o,
   input  wire             tx_ready_i,
   output wire [7:0]       tx_data_o,
   output reg              fifo_overflow_err_o,
   input  wire             crc_calc_start_i,
   input  wire             crc_calc_end_i,
   input  wire             crc_zero_i,
   input  wire             crc_compute_cmd_i,
   input  wire [IRQ_N-1:0] irq_req_i,
   input  wire [IRQ_N-1:0] irq_en_i,
   input  wire             timer_counting_i,
   input  wire             timer_armed_i,
   input  wire [1:0]       timer_gate_sel_i,
   input  wire             temp_alarm_i,
   output reg              temp_err_clr_o,
   input  wire             i2c_hs_proto_i,
   output wire             filter_fast_mode_o,
   input  wire             card_auth_ok_i,
   input  wire [2:0]       modem_phase_i,
   output wire             near_full_alert_o,
   output wire             near_empty_alert_o
);
   // ****************************************************************
   // Register state
   // ****************************************************************
   reg  [5:0]    warn_threshold;
   reg           crc_result_zero;
   reg           crc_done;
   reg           overheat_clear;
   reg           bus_filter_force_fast;
   reg           cipher_unit_on;
   reg           temp_meta;
   reg           temp_sync;
   reg  [7:0]    next_rdata;

   wire          wr_data;
   wire          rd_data;
   wire          wr_level;
   wire          wr_status2;
   wire          fifo_flush;
   wire [AW:0]   fifo_fill_count;
   wire [AW:0]   free_space;
   wire          buf_in_ready;
   wire          buf_out_valid;
   wire [7:0]    buf_out_data;
   wire          host_pop;
   wire          buf_push_valid;
   wire [7:0]    buf_push_data;
   wire          stg_valid;
   wire [7:0]    stg_data;
   wire          stg_ready;
   wire          stg_in_ready;
   wire          overflow_evt;
   wire          timer_active;
   wire          irq_pending;
   wire [7:0]    status1;
   wire [7:0]    status2;

   function sel;
      input [5:0] addr;
      input [5:0] off;
      begin
         sel = (addr == off);
      end
   endfunction

   // Reset pattern of the first status register; the CRC flags take
   // their reset levels from it so the two can never drift apart.
   localparam [7:0] RST_S1 = `FSR_RST_STATUS1;

   assign wr_data    = reg_wr_i & sel(reg_addr_i, `FSR_OFF_DATA);
   assign rd_data    = reg_rd_i & sel(reg_addr_i, `FSR_OFF_DATA);
   assign wr_level   = reg_wr_i & sel(reg_addr_i, `FSR_OFF_LEVEL);
   assign wr_status2 = reg_wr_i & sel(reg_addr_i, `FSR_OFF_STATUS2);
   assign fifo_flush = wr_level & reg_wdata_i[`FSR_LVL_FLUSH];

   // ****************************************************************
   // Staging buffer for the receiver and the main 64-byte buffer
   // ****************************************************************
   // The receiver lands in a small staging FIFO so that a host write
   // taking the main buffer's write slot stalls it instead of losing it.
   fsr_fifo #(
      .WIDTH (8),
      .DEPTH (STG_DEPTH),
      .AW    (STG_AW)
   ) u_stage (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (fifo_flush),
      .in_valid_i  (rx_valid_i),
      .in_ready_o  (stg_in_ready),
      .in_data_i   (rx_data_i),
      .out_valid_o (stg_valid),
      .out_ready_i (stg_ready),
      .out_data_o  (stg_data),
      .count_o     ()
   );

   assign rx_ready_o     = stg_in_ready;
   assign stg_ready      = ~wr_data & buf_in_ready;
   assign buf_push_valid = wr_data | stg_valid;
   assign buf_push_data  = wr_data ? reg_wdata_i : stg_data;
   // An empty buffer has no valid output, so a host pop does nothing.
   assign host_pop       = rd_data & buf_out_valid;
   assign tx_valid_o     = buf_out_valid & ~rd_data;
   assign tx_data_o      = buf_out_data;

   fsr_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_buf (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (fifo_flush),
      .in_valid_i  (buf_push_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (buf_push_data),
      .out_valid_o (buf_out_valid),
      .out_ready_i (host_pop | tx_ready_i),
      .out_data_o  (buf_out_data),
      .count_o     (fifo_fill_count)
   );

   // Overflow: host write into a full buffer, or receiver blocked by a
   // full staging FIFO while the main buffer is full.
   assign overflow_evt = (wr_data & ~buf_in_ready) |
                         (rx_valid_i & ~stg_in_ready & ~buf_in_ready);

   // A fresh overflow in the flush cycle survives it, so none is missed.
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fifo_overflow_err_o <= 1'b0;
      end else if (overflow_evt) begin
         fifo_overflow_err_o <= 1'b1;
      end else if (fifo_flush) begin
         fifo_overflow_err_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Alerts
   // ****************************************************************
   assign free_space = DEPTH[AW:0] - fifo_fill_count;
   assign near_full_alert_o  = (free_space <= {1'b0, warn_threshold});
   assign near_empty_alert_o = (fifo_fill_count <= {1'b0, warn_threshold});

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         warn_threshold <= `FSR_RST_WARN;
      end else if (reg_wr_i && sel(reg_addr_i, `FSR_OFF_WARN)) begin
         warn_threshold <= reg_wdata_i[`FSR_WARN_HI:0];
      end
   end

   // ****************************************************************
   // CRC, interrupt and timer status
   // ****************************************************************
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         crc_result_zero <= RST_S1[`FSR_S1_CRC_ZERO];
         crc_done        <= RST_S1[`FSR_S1_CRC_DONE];
      end else begin
         if (crc_calc_end_i) begin
            crc_result_zero <= crc_zero_i;
         end else if (crc_calc_start_i) begin
            crc_result_zero <= 1'b0;
         end
         if (crc_calc_end_i && crc_compute_cmd_i) begin
            crc_done <= 1'b1;
         end else if (crc_calc_start_i) begin
            crc_done <= 1'b0;
         end
      end
   end

   assign irq_pending  = |(irq_req_i & irq_en_i);
   // Gated mode reports the arming by gate selection, never the gate.
   assign timer_active = (timer_gate_sel_i != `FSR_GATE_OFF) ?
                         timer_armed_i : timer_counting_i;

   assign status1 = {1'b0, crc_result_zero, crc_done, irq_pending,
                     timer_active, 1'b0, near_full_alert_o,
                     near_empty_alert_o};

   // ****************************************************************
   // Temperature, bus filter, cipher and modem phase
   // ****************************************************************
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         temp_meta <= 1'b0;
         temp_sync <= 1'b0;
      end else begin
         temp_meta <= temp_alarm_i;
         temp_sync <= temp_meta;
      end
   end

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overheat_clear        <= 1'b0;
         bus_filter_force_fast <= 1'b0;
         cipher_unit_on        <= 1'b0;
         temp_err_clr_o        <= 1'b0;
      end else begin
         temp_err_clr_o <= wr_status2 & reg_wdata_i[`FSR_S2_OVH_CLR] &
                           ~temp_sync;
         if (wr_status2) begin
            overheat_clear        <= reg_wdata_i[`FSR_S2_OVH_CLR];
            bus_filter_force_fast <= reg_wdata_i[`FSR_S2_FAST];
         end
         // Authentication success wins over a same-cycle software clear.
         if (card_auth_ok_i) begin
            cipher_unit_on <= 1'b1;
         end else if (wr_status2 && !reg_wdata_i[`FSR_S2_CIPHER]) begin
            cipher_unit_on <= 1'b0;
         end
      end
   end

   assign filter_fast_mode_o = bus_filter_force_fast | i2c_hs_proto_i;

   // Phase codes come straight from the modem sequencer.
   assign status2 = {overheat_clear, bus_filter_force_fast, 2'b00,
                     cipher_unit_on, modem_phase_i};

   // ****************************************************************
   // Read port
   // ****************************************************************
   always @* begin
      next_rdata = 8'h00;
      case (reg_addr_i)
         `FSR_OFF_STATUS1: next_rdata = status1;
         `FSR_OFF_STATUS2: next_rdata = status2;
         `FSR_OFF_DATA:    next_rdata = buf_out_valid ? buf_out_data : 8'h00;
         `FSR_OFF_LEVEL:   next_rdata = {1'b0, fifo_fill_count};
         `FSR_OFF_WARN:    next_rdata = {2'b00, warn_threshold};
         default:          next_rdata = 8'h00;
      endcase
   end

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end
endmodule // fsr_regs

// [fsr_regs_props.sv]
// Purpose: Port checker for the buffer and status slice.
// Assumes: Read answers come one cycle after the read strobe.
// Notes:   Bound to every slice instance at the foot of this file.
`timescale 1ns/1ps
`include "fsr_consts.vh"
module fsr_regs_props #(
   parameter IRQ_N = 16
) (
   input wire             core_clk_i,
   input wire             rst_n_i,
   input wire [5:0]       reg_addr_i,
   input wire             reg_wr_i,
   input wire             reg_rd_i,
   input wire [7:0]       reg_wdata_i,
   input wire [7:0]       reg_rdata_o,
   input wire             reg_rvalid_o,
   input wire             rx_valid_i,
   input wire             tx_valid_o,
   input wire             fifo_overflow_err_o,
   input wire [IRQ_N-1:0] irq_req_i,
   input wire [IRQ_N-1:0] irq_en_i,
   input wire             timer_counting_i,
   input wire             timer_armed_i,
   input wire [1:0]       timer_gate_sel_i,
   input wire             temp_alarm_i,
   input wire             temp_err_clr_o,
   input wire [2:0]       modem_phase_i
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire rd_s1 = reg_rd_i && reg_addr_i == `FSR_OFF_STATUS1;
   wire rd_s2 = reg_rd_i && reg_addr_i == `FSR_OFF_STATUS2;
   wire wr_s2 = reg_wr_i && reg_addr_i == `FSR_OFF_STATUS2;
   wire flush = reg_wr_i && reg_addr_i == `FSR_OFF_LEVEL && reg_wdata_i[7];
   // ********
   // Rules
   // ********
   property p_rd_ans; reg_rd_i |=> reg_rvalid_o; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("no answer");
   property p_irq; rd_s1 |=> reg_rdata_o[4] == |$past(irq_req_i & irq_en_i);
   endproperty
   a_irq: assert property (p_irq) else $error("irq bit");
   property p_tmr; rd_s1 && timer_gate_sel_i == `FSR_GATE_OFF && !timer_armed_i
      |=> reg_rdata_o[3] == $past(timer_counting_i); endproperty
   a_tmr: assert property (p_tmr) else $error("timer bit");
   property p_gate; rd_s1 && timer_gate_sel_i != 2'h0 && timer_armed_i
      |=> reg_rdata_o[3]; endproperty
   a_gate: assert property (p_gate) else $error("gated timer");
   property p_phase; rd_s2 |=> reg_rdata_o[2:0] == $past(modem_phase_i)
      && reg_rdata_o[5:4] == 2'h0; endproperty
   a_phase: assert property (p_phase) else $error("phase");
   property p_flrb; reg_rd_i && reg_addr_i == `FSR_OFF_LEVEL
      |=> !reg_rdata_o[7]; endproperty
   a_flrb: assert property (p_flrb) else $error("flush bit");
   property p_flclr; flush && !rx_valid_i |=> !fifo_overflow_err_o; endproperty
   a_flclr: assert property (p_flclr) else $error("flush");
   property p_ovf; fifo_overflow_err_o && !flush |=> fifo_overflow_err_o;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow lost");
   property p_tclr; wr_s2 && reg_wdata_i[7] && !temp_alarm_i
      && !$past(temp_alarm_i) && !$past(temp_alarm_i, 2) |=> temp_err_clr_o;
   endproperty
   a_tclr: assert property (p_tclr) else $error("no temp clear");
   property p_tcause; temp_err_clr_o |-> $past(wr_s2 && reg_wdata_i[7]);
   endproperty
   a_tcause: assert property (p_tcause) else $error("stray");
   property p_txh; reg_rd_i && reg_addr_i == `FSR_OFF_DATA |-> !tx_valid_o;
   endproperty
   a_txh: assert property (p_txh) else $error("tx in read");
endmodule // fsr_regs_props
bind fsr_regs fsr_regs_props #(.IRQ_N(IRQ_N)) i_props (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .rx_valid_i(rx_valid_i), .tx_valid_o(tx_valid_o),
   .fifo_overflow_err_o(fifo_overflow_err_o),
   .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
   .timer_counting_i(timer_counting_i), .timer_armed_i(timer_armed_i),
   .timer_gate_sel_i(timer_gate_sel_i), .temp_alarm_i(temp_alarm_i),
   .temp_err_clr_o(temp_err_clr_o), .modem_phase_i(modem_phase_i));

// [fsr_stream_peer.sv]
// Purpose: Receiver source and stalling transmitter sink.
// Assumes: Signals change on the falling clock edge.
// Notes:   Idle receive data is the inverse of the last byte.
`timescale 1ns/1ps
module fsr_stream_peer (
   input  wire       core_clk_i,
   output reg        rx_valid_o,
   input  wire       rx_ready_i,
   output reg  [7:0] rx_data_o,
   input  wire       tx_valid_i,
   output reg        tx_ready_o,
   input  wire [7:0] tx_data_i
);
   reg     [7:0] got [0:127];
   reg           sink_en = 1'b0;
   integer       n_got = 0;
   integer       ph = 0;
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      tx_ready_o = 1'b0;
   end
   // The sink accepts one cycle in three so the buffer sees back-pressure.
   always @(negedge core_clk_i) begin
      ph = ph + 1;
      tx_ready_o <= sink_en && (ph % 3 == 0);
   end
   always @(posedge core_clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         got[n_got] = tx_data_i;
         n_got = n_got + 1;
      end
   end
   task send(input [7:0] b, output ok);
      integer w;
      begin
         @(negedge core_clk_i);
         rx_valid_o = 1'b1;
         rx_data_o = b;
         ok = 1'b0;
         w = 0;
         while (!ok && w < 20) begin
            @(posedge core_clk_i);
            if (rx_ready_i) ok = 1'b1;
            else w = w + 1;
         end
         @(negedge core_clk_i);
         rx_valid_o = 1'b0;
         rx_data_o = ~b;
      end
   endtask
endmodule // fsr_stream_peer

// [fsr_regs_tb.sv]
// Purpose: Self-checking bench for the buffer and status slice.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Stream traffic comes from the peer model.
`timescale 1ns/1ps
`include "fsr_consts.vh"
module fsr_regs_tb;
   reg        core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, ok;
   reg  [5:0] reg_addr_i;
   reg  [7:0] reg_wdata_i, d;
   reg        crc_calc_start_i, crc_calc_end_i, crc_zero_i, crc_compute_cmd_i;
   reg        timer_counting_i, timer_armed_i, temp_alarm_i;
   reg        i2c_hs_proto_i, card_auth_ok_i;
   reg  [1:0] timer_gate_sel_i;
   reg  [2:0] modem_phase_i;
   reg [15:0] irq_req_i, irq_en_i;
   wire [7:0] reg_rdata_o, rx_data_i, tx_data_o;
   wire       reg_rvalid_o, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
   wire       fifo_overflow_err_o, temp_err_clr_o, filter_fast_mode_o;
   wire       near_full_alert_o, near_empty_alert_o;
   integer    n_errors, cmp_count, i;
   fsr_regs i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .rx_valid_i(rx_valid_i),
      .rx_ready_o(rx_ready_o), .rx_data_i(rx_data_i),
      .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
      .fifo_overflow_err_o(fifo_overflow_err_o),
      .crc_calc_start_i(crc_calc_start_i), .crc_calc_end_i(crc_calc_end_i),
      .crc_zero_i(crc_zero_i), .crc_compute_cmd_i(crc_compute_cmd_i),
      .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
      .timer_counting_i(timer_counting_i), .timer_armed_i(timer_armed_i),
      .timer_gate_sel_i(timer_gate_sel_i), .temp_alarm_i(temp_alarm_i),
      .temp_err_clr_o(temp_err_clr_o), .i2c_hs_proto_i(i2c_hs_proto_i),
      .filter_fast_mode_o(filter_fast_mode_o),
      .card_auth_ok_i(card_auth_ok_i), .modem_phase_i(modem_phase_i),
      .near_full_alert_o(near_full_alert_o),
      .near_empty_alert_o(near_empty_alert_o));
   fsr_stream_peer i_peer (.core_clk_i(core_clk_i), .rx_valid_o(rx_valid_i),
      .rx_ready_i(rx_ready_o), .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o),
      .tx_ready_o(tx_ready_i), .tx_data_i(tx_data_o));
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   task check(input [7:0] seen, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [5:0] a, input [7:0] v);
      begin
         @(negedge core_clk_i);
         reg_addr_i = a;
         reg_wdata_i = v;
         reg_wr_i = 1'b1;
         @(negedge core_clk_i);
         reg_wr_i = 1'b0;
      end
   endtask
   task rd(input [5:0] a);
      begin
         @(negedge core_clk_i);
         reg_addr_i = a;
         reg_rd_i = 1'b1;
         @(negedge core_clk_i);
         reg_rd_i = 1'b0;
         d = reg_rdata_o;
         check({7'h0, reg_rvalid_o}, 8'h01);
      end
   endtask
   task give_verdict;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // ********
   // Scenarios
   // ********
   task t_port;
      begin
         rd(`FSR_OFF_STATUS1); check(d, 8'h21);
         rd(`FSR_OFF_WARN); check(d, 8'h08);
         wr(`FSR_OFF_WARN, 8'hff);
         rd(`FSR_OFF_WARN); check(d, 8'h3f);
         rd(6'h0c); check(d, 8'h00);
         wr(`FSR_OFF_WARN, 8'h04);
         for (i = 1; i <= 64; i = i + 1) begin
            wr(`FSR_OFF_DATA, i[7:0]);
            check({near_full_alert_o, near_empty_alert_o},
               {(64 - i) <= 4, i <= 4});
         end
         wr(`FSR_OFF_DATA, 8'hee);
         check(fifo_overflow_err_o, 1'b1);
         rd(`FSR_OFF_LEVEL); check(d, 8'h40);
         for (i = 1; i <= 62; i = i + 1) begin
            rd(`FSR_OFF_DATA); check(d, i[7:0]);
         end
         rd(`FSR_OFF_LEVEL); check(d, 8'h02);
         wr(`FSR_OFF_LEVEL, 8'h80);
         check(fifo_overflow_err_o, 1'b0);
         rd(`FSR_OFF_LEVEL); check(d, 8'h00);
         rd(`FSR_OFF_DATA); check(d, 8'h00);
         rd(`FSR_OFF_LEVEL); check(d, 8'h00);
         wr(`FSR_OFF_DATA, 8'h5a);
         rd(`FSR_OFF_DATA); check(d, 8'h5a);
         $display("test port done");
      end
   endtask
   task t_stream;
      begin
         for (i = 0; i < 72; i = i + 1) begin
            i_peer.send(i[7:0] ^ 8'ha5, ok); check(ok, 1'b1);
         end
         i_peer.send(8'h00, ok); check(ok, 1'b0);
         check(fifo_overflow_err_o, 1'b1);
         rd(`FSR_OFF_LEVEL); check(d, 8'h40);
         i_peer.sink_en = 1'b1;
         i = 0;
         while (i_peer.n_got < 72 && i < 2000) begin
            @(negedge core_clk_i);
            i = i + 1;
         end
         i_peer.sink_en = 1'b0;
         for (i = 0; i < 72; i = i + 1)
            check(i_peer.got[i], i[7:0] ^ 8'ha5);
         rd(`FSR_OFF_LEVEL); check(d, 8'h00);
         wr(`FSR_OFF_LEVEL, 8'h80);
         $display("test stream done");
      end
   endtask
   task t_status;
      begin
         @(negedge core_clk_i); crc_calc_start_i = 1'b1;
         @(negedge core_clk_i); crc_calc_start_i = 1'b0;
         crc_zero_i = 1'b1;
         @(negedge core_clk_i); crc_calc_end_i = 1'b1;
         @(negedge core_clk_i); crc_calc_end_i = 1'b0;
         rd(`FSR_OFF_STATUS1); check(d[6:5], 2'h2);
         @(negedge core_clk_i); crc_calc_start_i = 1'b1;
         @(negedge core_clk_i); crc_calc_start_i = 1'b0;
         rd(`FSR_OFF_STATUS1); check(d[6], 1'b0);
         crc_compute_cmd_i = 1'b1;
         @(negedge core_clk_i); crc_calc_end_i = 1'b1;
         @(negedge core_clk_i); crc_calc_end_i = 1'b0;
         rd(`FSR_OFF_STATUS1); check(d[6:5], 2'h3);
         irq_req_i = 16'h0008;
         rd(`FSR_OFF_STATUS1); check(d[4], 1'b0);
         irq_en_i = 16'h0008;
         rd(`FSR_OFF_STATUS1); check(d[4], 1'b1);
         timer_counting_i = 1'b1;
         rd(`FSR_OFF_STATUS1); check(d[3], 1'b1);
         timer_counting_i = 1'b0;
         rd(`FSR_OFF_STATUS1); check(d[3], 1'b0);
         timer_gate_sel_i = 2'h1;
         timer_armed_i = 1'b1;
         rd(`FSR_OFF_STATUS1); check(d[3], 1'b1);
         wr(`FSR_OFF_STATUS2, 8'h48);
         check(filter_fast_mode_o, 1'b1);
         rd(`FSR_OFF_STATUS2); check(d, 8'h40);
         @(negedge core_clk_i); card_auth_ok_i = 1'b1;
         @(negedge core_clk_i); card_auth_ok_i = 1'b0;
         rd(`FSR_OFF_STATUS2); check(d, 8'h48);
         wr(`FSR_OFF_STATUS2, 8'h00);
         check(filter_fast_mode_o, 1'b0);
         i2c_hs_proto_i = 1'b1;
         rd(`FSR_OFF_STATUS2); check(d, 8'h00);
         check(filter_fast_mode_o, 1'b1);
         wr(`FSR_OFF_STATUS2, 8'h80);
         check(temp_err_clr_o, 1'b1);
         temp_alarm_i = 1'b1;
         repeat (4) @(negedge core_clk_i);
         wr(`FSR_OFF_STATUS2, 8'h80);
         check(temp_err_clr_o, 1'b0);
         for (i = 0; i < 7; i = i + 1) begin
            modem_phase_i = i[2:0];
            rd(`FSR_OFF_STATUS2);
            check(d, 8'h80 | i[7:0]);
         end
         $display("test status done");
      end
   endtask
   initial begin
      {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 0;
      {crc_calc_start_i, crc_calc_end_i, crc_zero_i, crc_compute_cmd_i} = 0;
      {timer_counting_i, timer_armed_i, timer_gate_sel_i, temp_alarm_i} = 0;
      {i2c_hs_proto_i, card_auth_ok_i, modem_phase_i} = 0;
      {irq_req_i, irq_en_i} = 0;
      n_errors = 0;
      cmp_count = 0;
      repeat (8) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      t_port;
      t_stream;
      t_status;
      give_verdict;
   end
   // The run needs about 740 cycles; the limit of 15000 cycles leaves ample margin.
   initial begin
      #60000;
      n_errors = n_errors + 1;
      give_verdict;
   end
endmodule // fsr_regs_tb
